// *** fe_ctrl_pkg.sv ***
package fe_ctrl_pkg;

   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [9:0] mode_select_addr     = 10'h022;
   localparam logic [9:0] line_one_value_addr  = 10'h032;
   localparam logic [9:0] line_two_value_addr  = 10'h033;
   localparam logic [9:0] direction_addr       = 10'h034;
   localparam logic [9:0] tx_power_addr        = 10'h203;

   // ----------------------------------------------------------------
   // Field layout and values
   // ----------------------------------------------------------------
   localparam int         mode_field_lsb       = 0;
   localparam int         mode_field_msb       = 2;
   localparam logic [2:0] mode_auto            = 3'h7;
   localparam logic [2:0] mode_normal          = 3'h0;
   localparam int         power_field_lsb      = 3;
   localparam int         power_field_msb      = 7;
   localparam logic [4:0] power_lowest         = 5'h1f;
   localparam logic [4:0] power_highest_char   = 5'h05;
   localparam int         num_lines            = 3;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] mode_select_rst      = 8'h00;
   localparam logic [7:0] line_value_rst       = 8'h00;
   localparam logic [7:0] direction_rst        = 8'h00;
   localparam logic [7:0] tx_power_rst         = 8'h00;

endpackage

// *** fe_line_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface fe_line_if;
   logic       auto_mode;
   logic [2:0] sm_drive;
   logic [2:0] out_value;
   logic [2:0] direction;
   logic [2:0] line_out;
   logic [2:0] line_oe;

   modport regs (output auto_mode, output sm_drive, output out_value, output direction,
                 input line_out, input line_oe);
   modport mux  (input auto_mode, input sm_drive, input out_value, input direction,
                 output line_out, output line_oe);
endinterface
`default_nettype wire

// *** fe_line_mux.sv ***
`timescale 1ns/1ns
`default_nettype none
module fe_line_mux
   import fe_ctrl_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic srst,
   fe_line_if.mux    lines
);
   typedef struct packed
   {
      logic [2:0] out_q;
      logic [2:0] oe_q;
   } mux_state_t;

   mux_state_t state_q;
   mux_state_t state_d;

   // ----------------------------------------------------------------
   // Per-line source select
   // ----------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      for (int i = 0; i < num_lines; i++)
      begin
         if (lines.auto_mode)
         begin
            state_d.out_q[i] = lines.sm_drive[i];
            state_d.oe_q[i]  = 1'b1;
         end
         else
         begin
            state_d.out_q[i] = lines.out_value[i];
            state_d.oe_q[i]  = lines.direction[i];
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
         state_q <= '0;
      else
         state_q <= state_d;
   end

   assign lines.line_out = state_q.out_q;
   assign lines.line_oe  = state_q.oe_q;
endmodule
`default_nettype wire

// *** rf_front_end_switch_control.sv ***
`timescale 1ns/1ns
`default_nettype none
module rf_front_end_switch_control
   import fe_ctrl_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       srst,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [9:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   input  wire logic [2:0] sm_line_drive,
   output logic      [2:0] front_end_line_out,
   output logic      [2:0] front_end_line_oe,
   output logic      [4:0] transmit_power_field
);
   typedef struct packed
   {
      logic [7:0] mode_q;
      logic [7:0] line_one_q;
      logic [7:0] line_two_q;
      logic [7:0] dir_q;
      logic [7:0] power_q;
      logic [7:0] rdata_q;
   } regs_state_t;

   regs_state_t state_q;
   regs_state_t state_d;
   fe_line_if   lines ();

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      if (reg_wr)
      begin
         case (reg_addr)
            mode_select_addr:    state_d.mode_q     = reg_wdata;
            line_one_value_addr: state_d.line_one_q = reg_wdata;
            line_two_value_addr: state_d.line_two_q = reg_wdata;
            direction_addr:      state_d.dir_q      = reg_wdata;
            tx_power_addr:       state_d.power_q    = reg_wdata;
            default:             state_d.rdata_q    = state_q.rdata_q;
         endcase
      end
      if (reg_rd)
      begin
         case (reg_addr)
            mode_select_addr:    state_d.rdata_q = state_q.mode_q;
            line_one_value_addr: state_d.rdata_q = state_q.line_one_q;
            line_two_value_addr: state_d.rdata_q = state_q.line_two_q;
            direction_addr:      state_d.rdata_q = state_q.dir_q;
            tx_power_addr:       state_d.rdata_q = state_q.power_q;
            default:             state_d.rdata_q = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         state_q.mode_q     <= mode_select_rst;
         state_q.line_one_q <= line_value_rst;
         state_q.line_two_q <= line_value_rst;
         state_q.dir_q      <= direction_rst;
         state_q.power_q    <= tx_power_rst;
         state_q.rdata_q    <= 8'h00;
      end
      else
         state_q <= state_d;
   end

   // ----------------------------------------------------------------
   // Line source wiring
   // ----------------------------------------------------------------
   // Line zero value has no register of its own; bit 0 of line one's register serves.
   assign lines.auto_mode = (state_q.mode_q[mode_field_msb:mode_field_lsb] == mode_auto);
   assign lines.sm_drive  = sm_line_drive;
   assign lines.out_value = {state_q.line_two_q[2], state_q.line_one_q[1],
                             state_q.line_one_q[0]};
   assign lines.direction = state_q.dir_q[num_lines-1:0];

   fe_line_mux u_mux
   (
      .core_clk (core_clk),
      .srst     (srst),
      .lines    (lines.mux)
   );

   assign front_end_line_out   = lines.line_out;
   assign front_end_line_oe    = lines.line_oe;
   assign reg_rdata            = state_q.rdata_q;
   assign transmit_power_field = state_q.power_q[power_field_msb:power_field_lsb];
endmodule
`default_nettype wire

// *** fe_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module fe_host
(
   input  wire logic       core_clk,
   output logic            reg_wr    = 1'b0,
   output logic            reg_rd    = 1'b0,
   output logic      [9:0] reg_addr  = 10'h000,
   output logic      [7:0] reg_wdata = 8'h00,
   input  wire logic [7:0] reg_rdata
);
   task automatic io(input logic w, input logic [9:0] a, input logic [7:0] d);
      @(posedge core_clk);
      {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
      @(posedge core_clk);
      {reg_wr, reg_rd, reg_wdata} <= {2'b00, ~d};
      #1;
   endtask
endmodule
`default_nettype wire

// *** fe_line_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module fe_chk
   import fe_ctrl_pkg::*;
(
   input wire logic       core_clk,
   input wire logic       srst,
   input wire logic       reg_wr,
   input wire logic [9:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [2:0] sm_line_drive,
   input wire logic [2:0] front_end_line_out,
   input wire logic [2:0] front_end_line_oe,
   input wire logic [4:0] transmit_power_field
);
   logic [2:0] m_q;
   wire        wm = reg_wr && reg_addr == mode_select_addr;
   wire        wp = reg_wr && reg_addr == tx_power_addr;
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   always_ff @(posedge core_clk)
      m_q <= srst ? mode_normal : wm ? reg_wdata[2:0] : m_q;
   sequence s_auto; wm && reg_wdata[2:0] == mode_auto ##1 1'b1; endsequence
   sequence s_dir; m_q != mode_auto && reg_wr && reg_addr == direction_addr ##1 !wm; endsequence
   sequence s_idle; m_q != mode_auto && !reg_wr ##1 !reg_wr; endsequence
   a_auto_lines: assert property (s_auto |=> front_end_line_oe == 3'h7 &&
      front_end_line_out == $past(sm_line_drive)) else $error("auto lines");
   a_auto_follow: assert property (m_q == mode_auto |=>
      front_end_line_oe == 3'h7 && front_end_line_out == $past(sm_line_drive))
      else $error("auto follow");
   a_manual_hold: assert property (s_idle |=>
      $stable(front_end_line_out & front_end_line_oe)) else $error("manual lines");
   a_dir_drive: assert property (s_dir |=>
      front_end_line_oe == $past(reg_wdata[2:0], 2)) else $error("direction");
   a_power_store: assert property (wp |=>
      transmit_power_field == $past(reg_wdata[7:3])) else $error("power");
   a_low_codes: assert property (wp && reg_wdata[7:3] < power_highest_char |=>
      transmit_power_field == $past(reg_wdata[7:3])) else $error("low code");
endmodule
bind rf_front_end_switch_control fe_chk chk_u (.*);
`default_nettype wire

// *** rf_front_end_switch_control_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin fail_count++; $display("unexpected %s %h %h", n, e, s); end end
module rf_front_end_switch_control_tb
   import fe_ctrl_pkg::*;
;
   logic       core_clk = 1'b0, srst = 1'b1, reg_wr, reg_rd;
   logic [9:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic [2:0] sm_line_drive = 3'h0, front_end_line_out, front_end_line_oe;
   logic [4:0] transmit_power_field;
   logic [8:0] r;
   logic [2:0] sm_prev;
   int         fail_count = 0, n_checks = 0, cyc = 0;
   fe_host host (.*);
   rf_front_end_switch_control dut_u (.*);
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) sm_line_drive <= 3'($urandom);
   always @(posedge core_clk) sm_prev <= sm_line_drive;
   always @(posedge core_clk) if (++cyc == 9000) finish_test(1);
   function automatic logic [2:0] exp_out(logic [8:0] v); return {v[2], v[4:3]} & v[8:6]; endfunction
   task automatic finish_test(input int extra);
      fail_count += extra;
      if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      void'($urandom(86384));
      repeat (12) @(posedge core_clk);
      srst <= 1'b0;
      host.io(1'b0, mode_select_addr, 8'h0);
      `CHK("mode rst", mode_select_rst, reg_rdata)
      host.io(1'b1, mode_select_addr, 8'(mode_normal));
      for (int i = 0; i < 10; i++)
      begin
         r = i == 0 ? 9'o604 : i == 1 ? 9'o700 : 9'($urandom);
         host.io(1'b1, direction_addr, 8'(r[8:6]));
         host.io(1'b1, line_one_value_addr, 8'(r[5:3]));
         host.io(1'b1, line_two_value_addr, 8'(r[2:0]));
         repeat (2) @(posedge core_clk) #1;
         `CHK("oe", r[8:6], front_end_line_oe)
         `CHK("out", exp_out(r), front_end_line_out & r[8:6])
      end
      host.io(1'b1, mode_select_addr, 8'(mode_auto));
      host.io(1'b0, mode_select_addr, 8'h0);
      `CHK("mode", 8'(mode_auto), reg_rdata)
      host.io(1'b0, 10'h100, 8'h0);
      `CHK("unmapped", 8'h00, reg_rdata)
      for (int k = 0; k < 8; k++)
      begin
         @(posedge core_clk) #1;
         `CHK("auto out", sm_prev, front_end_line_out)
         `CHK("auto oe", 3'h7, front_end_line_oe)
      end
      for (int c = 0; c < 32; c++)
      begin
         host.io(1'b1, tx_power_addr, {5'(31 - c), 3'($urandom)});
         host.io(1'b0, tx_power_addr, 8'h0);
         `CHK("power", 5'(31 - c), reg_rdata[7:3])
         `CHK("power pin", 5'(31 - c), transmit_power_field)
      end
      @(posedge core_clk) srst <= 1'b1;
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk) #1;
      `CHK("oe rst", direction_rst[2:0], front_end_line_oe)
      `CHK("power rst", tx_power_rst[7:3], transmit_power_field)
      finish_test(0);
   end
endmodule
`default_nettype wire
